// file: spm_mode_select.sv
`timescale 1ns/1ps
`include "spm_consts.svh"
module spm_mode_select
  import spm_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `SPM_MS_CYCLES
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [15:0] regRdData,
  input wire logic paramSwDefault,
  input wire logic [3:0] modeSw,
  input wire logic [2:0] rioBaudSw,
  input wire logic [2:0] frameRx,
  input wire logic [2:0] ctsIn,
  output logic [2:0] rtsOut,
  output logic [2:0] txGo,
  output logic [2:0] rspDrop,
  input wire logic [2:0] monStart,
  input wire logic [2:0] monEnd,
  output logic [2:0] monGrant,
  input wire logic cycleStart,
  input wire logic logicDone,
  output logic commWindow,
  input wire logic faultIn,
  input wire logic takeoverReq,
  output logic unitActive,
  output logic remoteMaster,
  input wire logic rioPollNext,
  output logic [2:0] rioPollAddr,
  output logic [6:0] slaveAddr,
  output spm_baud_t baudP2p,
  output spm_baud_t baudMdA,
  output spm_baud_t baudMdB,
  output logic holdBlink
);
  logic [15:0] storeRd;
  logic [6:0] progAddr;
  spm_baud_t progBaudP2p, progBaudMd;
  logic [15:0] rtsTimeoutMs, respDelayMs, delayMs;
  logic [6:0] offDutyPct, pct;
  logic storeWr, storeSel, factoryLoad;

  // Register access
  assign storeWr = regWrEn && (regAddr < `SPM_OFF_STATUS) && (regAddr[1:0] == 2'b00);
  assign storeSel = regRdEn && (regAddr < `SPM_OFF_STATUS) && (regAddr[1:0] == 2'b00);

  spm_param_store u_store (
    .sys_clk(sys_clk),
    .rst(rst),
    .wrEn(storeWr),
    .wrIdx(regAddr[4:2]),
    .wrData(regWrData),
    .factoryLoad(factoryLoad),
    .rdEn(storeSel),
    .rdIdx(regAddr[4:2]),
    .rdData(storeRd),
    .progAddr(progAddr),
    .progBaudP2p(progBaudP2p),
    .progBaudMd(progBaudMd),
    .rtsTimeoutMs(rtsTimeoutMs),
    .respDelayMs(respDelayMs),
    .offDutyPct(offDutyPct)
  );

  // Startup capture of the mode switch and factory restore
  logic started_r, started_nxt, factDone_r, factDone_nxt;
  logic [3:0] mode_r, mode_nxt;
  logic [17:0] msPre_r, msPre_nxt;
  logic [8:0] blinkCnt_r, blinkCnt_nxt;
  logic blink_r, blink_nxt;
  logic msTick;

  assign factoryLoad = !started_r && (modeSw == `SPM_MODE_FACTORY) && paramSwDefault;
  assign msTick = (msPre_r == 18'(MS_CYCLES - 1));

  always_comb
  begin
    started_nxt = 1'b1;
    mode_nxt = started_r ? mode_r : modeSw;
    factDone_nxt = factDone_r || factoryLoad;
    msPre_nxt = msTick ? 18'h00000 : msPre_r + 18'h00001;
    blinkCnt_nxt = blinkCnt_r;
    blink_nxt = blink_r;
    if (factDone_r && msTick)
    begin
      blinkCnt_nxt = blinkCnt_r + 9'h001;
      if (blinkCnt_r == `SPM_BLINK_MS - 9'h001)
      begin
        blinkCnt_nxt = 9'h000;
        blink_nxt = !blink_r;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      started_r <= 1'b0;
      mode_r <= `SPM_MODE_SLAVE3;
      factDone_r <= 1'b0;
      msPre_r <= 18'h00000;
      blinkCnt_r <= 9'h000;
      blink_r <= 1'b0;
    end
    else
    begin
      started_r <= started_nxt;
      mode_r <= mode_nxt;
      factDone_r <= factDone_nxt;
      msPre_r <= msPre_nxt;
      blinkCnt_r <= blinkCnt_nxt;
      blink_r <= blink_nxt;
    end
  end

  assign holdBlink = blink_r;
  assign remoteMaster = started_r && (mode_r == `SPM_MODE_REMOTE);

  // Redundancy role, monitor lock and remote poll address
  logic active_r, active_nxt;
  logic [1:0] mon_r, mon_nxt;
  logic [2:0] poll_r, poll_nxt;

  always_comb
  begin
    if (active_r)
    begin
      active_nxt = !faultIn;
    end
    else
    begin
      active_nxt = takeoverReq && !faultIn;
    end
    mon_nxt = mon_r;
    if (mon_r == 2'h0)
    begin
      for (int i = 2; i >= 0; i--)
      begin
        if (monStart[i])
        begin
          mon_nxt = 2'(i + 1);
        end
      end
    end
    else if (monEnd[mon_r - 2'h1])
    begin
      mon_nxt = 2'h0;
    end
    poll_nxt = poll_r;
    if (rioPollNext && remoteMaster && active_r)
    begin
      poll_nxt = (poll_r == `SPM_RIO_LAST) ? `SPM_RIO_FIRST : poll_r + 3'h1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      active_r <= 1'b0;
      mon_r <= 2'h0;
      poll_r <= `SPM_RIO_FIRST;
    end
    else
    begin
      active_r <= active_nxt;
      mon_r <= mon_nxt;
      poll_r <= poll_nxt;
    end
  end

  assign unitActive = active_r;
  assign rioPollAddr = poll_r;

  genvar gm;
  generate
    for (gm = 0; gm < 3; gm++)
    begin : g_mon
      assign monGrant[gm] = (mon_r == 2'(gm + 1));
    end
  endgenerate

  // Effective address and baud rates
  logic [6:0] addr_r, addr_nxt;
  spm_baud_t bP2p_r, bP2p_nxt, bA_r, bA_nxt, bB_r, bB_nxt;

  always_comb
  begin
    // Switch position selects the source live, so writes made under defaults
    // wait in the store and programmed writes act at once
    addr_nxt = paramSwDefault ? `SPM_DEF_ADDR : progAddr;
    bP2p_nxt = paramSwDefault ? `SPM_BAUD_9600 : progBaudP2p;
    bA_nxt = paramSwDefault ? `SPM_BAUD_9600 : progBaudMd;
    bB_nxt = remoteMaster ? rioBaudSw : bA_nxt;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      addr_r <= `SPM_DEF_ADDR;
      bP2p_r <= `SPM_BAUD_9600;
      bA_r <= `SPM_BAUD_9600;
      bB_r <= `SPM_BAUD_9600;
    end
    else
    begin
      addr_r <= addr_nxt;
      bP2p_r <= bP2p_nxt;
      bA_r <= bA_nxt;
      bB_r <= bB_nxt;
    end
  end

  assign slaveAddr = addr_r;
  assign baudP2p = bP2p_r;
  assign baudMdA = bA_r;
  assign baudMdB = bB_r;

  // Off-duty window after each logic pass while the unit is active
  logic [23:0] cyc_r, cyc_nxt, last_r, last_nxt, off_r, off_nxt;
  logic [31:0] offProd;

  assign pct = (paramSwDefault || offDutyPct == 7'h00) ? `SPM_DEF_OFF_PCT : offDutyPct;
  assign offProd = (32'(last_r) * 32'(pct)) / `SPM_PCT_FULL;

  always_comb
  begin
    cyc_nxt = (cyc_r == 24'hFFFFFF) ? cyc_r : cyc_r + 24'h000001;
    last_nxt = last_r;
    if (cycleStart)
    begin
      cyc_nxt = 24'h000000;
      last_nxt = cyc_r;
    end
    off_nxt = (off_r != 24'h000000) ? off_r - 24'h000001 : off_r;
    if (logicDone && active_r)
    begin
      off_nxt = offProd[23:0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cyc_r <= 24'h000000;
      last_r <= 24'h000000;
      off_r <= 24'h000000;
    end
    else
    begin
      cyc_r <= cyc_nxt;
      last_r <= last_nxt;
      off_r <= off_nxt;
    end
  end

  assign commWindow = (off_r != 24'h000000);

  // Per-channel response sequencing
  assign delayMs = (respDelayMs == 16'h0000) ? `SPM_DEF_DLY_MS : respDelayMs;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_ch
      spm_rsp_e st_r, st_nxt;
      logic tStart, tStop, tExp, slaveOk;
      logic [15:0] tLoad;

      // Third port is taken off slave duty in remote mode
      assign slaveOk = (gi != 2) || !remoteMaster;

      always_comb
      begin
        st_nxt = st_r;
        tStart = 1'b0;
        tLoad = delayMs;
        case (st_r)
          RSP_IDLE:
            if (frameRx[gi] && slaveOk && active_r)
            begin
              st_nxt = RSP_DELAY;
              tStart = 1'b1;
            end
          RSP_DELAY:
            if (tExp)
            begin
              st_nxt = RSP_WAITCTS;
              tStart = 1'b1;
              tLoad = rtsTimeoutMs;
            end
          RSP_WAITCTS:
            if (ctsIn[gi])
            begin
              st_nxt = RSP_SEND;
            end
            else if (tExp)
            begin
              st_nxt = RSP_IDLE;
            end
          RSP_SEND:
            st_nxt = RSP_IDLE;
          default:
            st_nxt = RSP_IDLE;
        endcase
      end

      always_ff @(posedge sys_clk or posedge rst)
      begin
        if (rst)
        begin
          st_r <= RSP_IDLE;
        end
        else
        begin
          st_r <= st_nxt;
        end
      end

      assign tStop = (st_r == RSP_WAITCTS) && ctsIn[gi];

      spm_timer #(.MS_CYCLES(MS_CYCLES)) u_tmr (
        .sys_clk(sys_clk),
        .rst(rst),
        .start(tStart),
        .stop(tStop),
        .loadMs(tLoad),
        .expired(tExp)
      );

      assign rtsOut[gi] = (st_r == RSP_WAITCTS);
      assign txGo[gi] = (st_r == RSP_SEND);
      assign rspDrop[gi] = (st_r == RSP_WAITCTS) && !ctsIn[gi] && tExp;
    end
  endgenerate

  // Status readback
  logic [15:0] stRd_r, stRd_nxt;
  logic selStore_r;

  always_comb
  begin
    stRd_nxt = 16'h0000;
    if (regRdEn && regAddr == `SPM_OFF_STATUS)
    begin
      stRd_nxt[`SPM_ST_ACTIVE] = active_r;
      stRd_nxt[`SPM_ST_REMOTE] = remoteMaster;
      stRd_nxt[`SPM_ST_DEFSW] = paramSwDefault;
      stRd_nxt[`SPM_ST_FACTORY] = factDone_r;
      stRd_nxt[`SPM_ST_MON_LO +: 2] = mon_r;
      stRd_nxt[`SPM_ST_MODE_LO +: 4] = mode_r;
    end
    else if (regRdEn && regAddr == `SPM_OFF_EFFECT)
    begin
      stRd_nxt = {bB_r, bA_r, bP2p_r, addr_r};
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      stRd_r <= 16'h0000;
      selStore_r <= 1'b0;
    end
    else
    begin
      stRd_r <= stRd_nxt;
      selStore_r <= storeSel;
    end
  end

  assign regRdData = selStore_r ? storeRd : stRd_r;
endmodule

// file: spm_consts.svh
`ifndef SPM_CONSTS_SVH
`define SPM_CONSTS_SVH
// Clock and derived millisecond count
`define SPM_CLK_HZ 200000000
`define SPM_MS_CYCLES (`SPM_CLK_HZ / 1000)
// Register byte offsets
`define SPM_OFF_ADDR 8'h00
`define SPM_OFF_BAUD_P2P 8'h04
`define SPM_OFF_BAUD_MD 8'h08
`define SPM_OFF_RTS_TMO 8'h0C
`define SPM_OFF_RSP_DLY 8'h10
`define SPM_OFF_OFF_DUTY 8'h14
`define SPM_OFF_STATUS 8'h18
`define SPM_OFF_EFFECT 8'h1C
// Parameter store word indices
`define SPM_IDX_ADDR 3'h0
`define SPM_IDX_BAUD_P2P 3'h1
`define SPM_IDX_BAUD_MD 3'h2
`define SPM_IDX_RTS_TMO 3'h3
`define SPM_IDX_RSP_DLY 3'h4
`define SPM_IDX_OFF_DUTY 3'h5
`define SPM_STORE_WORDS 6
// Reset and factory values
`define SPM_DEF_ADDR 7'h01
`define SPM_BAUD_9600 3'h0
`define SPM_RST_ADDR 16'h0001
`define SPM_RST_BAUD 16'h0000
`define SPM_RST_RTS_TMO 16'h0064
`define SPM_RST_RSP_DLY 16'h0000
`define SPM_RST_OFF_DUTY 16'h0000
// Defaults applied when a setting is zero (the off-duty one also under the default switch), and the full-scale percent
`define SPM_DEF_DLY_MS 16'h0007
`define SPM_DEF_OFF_PCT 7'h14
`define SPM_PCT_FULL 32'h00000064
// Mode switch positions
`define SPM_MODE_REMOTE 4'h0
`define SPM_MODE_FACTORY 4'h7
`define SPM_MODE_SLAVE3 4'h8
// Remote unit addresses
`define SPM_RIO_FIRST 3'h1
`define SPM_RIO_LAST 3'h6
// Hold indicator half period in ms
`define SPM_BLINK_MS 9'h0FA
// Status field positions
`define SPM_ST_ACTIVE 0
`define SPM_ST_REMOTE 1
`define SPM_ST_DEFSW 2
`define SPM_ST_FACTORY 3
`define SPM_ST_MON_LO 4
`define SPM_ST_MODE_LO 6
`endif

// file: spm_pkg.sv
package spm_pkg;
  typedef enum logic [1:0] {
    RSP_IDLE = 2'b00,
    RSP_DELAY = 2'b01,
    RSP_WAITCTS = 2'b11,
    RSP_SEND = 2'b10
  } spm_rsp_e;
  typedef logic [2:0] spm_baud_t;
endpackage

// file: spm_timer.sv
`timescale 1ns/1ps
`include "spm_consts.svh"
module spm_timer
  import spm_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `SPM_MS_CYCLES
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic stop,
  input wire logic [15:0] loadMs,
  output logic expired
);
  localparam logic [17:0] PRE_LAST = 18'(MS_CYCLES - 1);
  logic run_r, run_nxt;
  logic [17:0] pre_r, pre_nxt;
  logic [15:0] left_r, left_nxt;
  logic msDone;

  assign msDone = run_r && (pre_r == PRE_LAST);
  assign expired = msDone && (left_r <= 16'h0001);

  always_comb
  begin
    run_nxt = run_r;
    pre_nxt = pre_r;
    left_nxt = left_r;
    if (start)
    begin
      // Prescaler restarts so the first millisecond is whole
      run_nxt = 1'b1;
      pre_nxt = 18'h00000;
      left_nxt = loadMs;
    end
    else if (stop || expired)
    begin
      run_nxt = 1'b0;
    end
    else if (run_r)
    begin
      pre_nxt = msDone ? 18'h00000 : pre_r + 18'h00001;
      if (msDone)
      begin
        left_nxt = left_r - 16'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      run_r <= 1'b0;
      pre_r <= 18'h00000;
      left_r <= 16'h0000;
    end
    else
    begin
      run_r <= run_nxt;
      pre_r <= pre_nxt;
      left_r <= left_nxt;
    end
  end
endmodule

// file: spm_param_store.sv
`timescale 1ns/1ps
`include "spm_consts.svh"
module spm_param_store
  import spm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic wrEn,
  input wire logic [2:0] wrIdx,
  input wire logic [15:0] wrData,
  input wire logic factoryLoad,
  input wire logic rdEn,
  input wire logic [2:0] rdIdx,
  output logic [15:0] rdData,
  output logic [6:0] progAddr,
  output spm_baud_t progBaudP2p,
  output spm_baud_t progBaudMd,
  output logic [15:0] rtsTimeoutMs,
  output logic [15:0] respDelayMs,
  output logic [6:0] offDutyPct
);
  logic [15:0] mem_r [`SPM_STORE_WORDS];
  logic [15:0] mem_nxt [`SPM_STORE_WORDS];
  logic [15:0] rd_r, rd_nxt;

  function automatic logic [15:0] resetWord(input int idx);
    case (idx)
      0: resetWord = `SPM_RST_ADDR;
      1: resetWord = `SPM_RST_BAUD;
      2: resetWord = `SPM_RST_BAUD;
      3: resetWord = `SPM_RST_RTS_TMO;
      4: resetWord = `SPM_RST_RSP_DLY;
      default: resetWord = `SPM_RST_OFF_DUTY;
    endcase
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < `SPM_STORE_WORDS; gi++)
    begin : g_word
      always_comb
      begin
        mem_nxt[gi] = mem_r[gi];
        if (factoryLoad)
        begin
          mem_nxt[gi] = resetWord(gi);
        end
        else if (wrEn && (wrIdx == 3'(gi)))
        begin
          mem_nxt[gi] = wrData;
        end
      end

      always_ff @(posedge sys_clk or posedge rst)
      begin
        if (rst)
        begin
          mem_r[gi] <= resetWord(gi);
        end
        else
        begin
          mem_r[gi] <= mem_nxt[gi];
        end
      end
    end
  endgenerate

  always_comb
  begin
    rd_nxt = 16'h0000;
    if (rdEn && (rdIdx < 3'(`SPM_STORE_WORDS)))
    begin
      rd_nxt = mem_r[rdIdx];
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rd_r <= 16'h0000;
    end
    else
    begin
      rd_r <= rd_nxt;
    end
  end

  assign rdData = rd_r;
  assign progAddr = mem_r[`SPM_IDX_ADDR][6:0];
  assign progBaudP2p = mem_r[`SPM_IDX_BAUD_P2P][2:0];
  assign progBaudMd = mem_r[`SPM_IDX_BAUD_MD][2:0];
  assign rtsTimeoutMs = mem_r[`SPM_IDX_RTS_TMO];
  assign respDelayMs = mem_r[`SPM_IDX_RSP_DLY];
  assign offDutyPct = mem_r[`SPM_IDX_OFF_DUTY][6:0];
endmodule

// file: spm_mode_select_asserts.sv
`timescale 1ns/1ps
module spm_mode_select_asserts
  import spm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic paramSwDefault,
  input wire logic [2:0] rioBaudSw,
  input wire logic [2:0] ctsIn,
  input wire logic [2:0] monStart,
  input wire logic [2:0] monEnd,
  input wire logic faultIn,
  input wire logic [2:0] rtsOut,
  input wire logic [2:0] txGo,
  input wire logic [2:0] rspDrop,
  input wire logic [2:0] monGrant,
  input wire logic unitActive,
  input wire logic remoteMaster,
  input wire logic [2:0] rioPollAddr,
  input wire logic [6:0] slaveAddr,
  input wire spm_baud_t baudP2p,
  input wire spm_baud_t baudMdA,
  input wire spm_baud_t baudMdB
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  cts_first_a: assert property ((txGo & ~$past(rtsOut & ctsIn)) == 3'h0)
    else $error("reply sent without handshake");
  tx_release_a: assert property (txGo != 3'h0 |->
    (rtsOut & txGo) == 3'h0 ##1 (txGo & $past(txGo)) == 3'h0)
    else $error("reply pulse or request line wrong");
  drop_release_a: assert property (rspDrop != 3'h0 |->
    (rtsOut & rspDrop) == rspDrop ##1 (rtsOut & $past(rspDrop)) == 3'h0)
    else $error("request line not released on drop");
  mon_single_a: assert property ($onehot0(monGrant))
    else $error("more than one monitor grant");
  mon_pick_a: assert property ((monGrant & ~$past(monGrant)) != 3'h0 |->
    $past(monGrant) == 3'h0 && (monGrant & ~$past(monStart)) == 3'h0
    && ($past(monStart) & (monGrant - 3'h1)) == 3'h0)
    else $error("monitor grant not given to lowest requester");
  mon_lock_a: assert property (monGrant != 3'h0 && (monEnd & monGrant) == 3'h0
    |=> monGrant == $past(monGrant))
    else $error("monitor grant moved while held");
  def_params_a: assert property (paramSwDefault && $past(paramSwDefault)
    |-> slaveAddr == 7'h01 && baudP2p == 3'h0 && baudMdA == 3'h0)
    else $error("default parameters not applied");
  md_shared_a: assert property (!remoteMaster |-> baudMdA == baudMdB)
    else $error("multidrop baud rates differ");
  rio_baud_a: assert property (remoteMaster && $past(remoteMaster)
    |-> baudMdB == $past(rioBaudSw))
    else $error("remote port baud not from switch");
  p3_blocked_a: assert property (remoteMaster |-> !rtsOut[2] && !txGo[2])
    else $error("third port answered in remote mode");
  active_hold_a: assert property (unitActive && !faultIn |=> unitActive)
    else $error("active unit gave up without fault");
  rio_range_a: assert property (rioPollAddr >= 3'h1 && rioPollAddr <= 3'h6)
    else $error("remote poll address out of range");
endmodule
bind spm_mode_select spm_mode_select_asserts spm_mode_select_asserts_i (
  .sys_clk, .rst, .paramSwDefault, .rioBaudSw, .ctsIn, .monStart, .monEnd, .faultIn, .rtsOut,
  .txGo, .rspDrop, .monGrant, .unitActive, .remoteMaster, .rioPollAddr, .slaveAddr,
  .baudP2p, .baudMdA, .baudMdB
);

// file: spm_host_model.sv
`timescale 1ns/1ps
module spm_host_model
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic sendReq,
  input wire logic [1:0] sendChan,
  input wire logic [7:0] ctsLag,
  input wire logic [2:0] rtsOut,
  output logic [2:0] frameRx,
  output logic [2:0] ctsIn
);
  logic [7:0] waitCnt [3];
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      frameRx <= 3'h0;
      ctsIn <= 3'h0;
    end
    else
    begin
      frameRx <= sendReq ? (3'h1 << sendChan) : 3'h0;
      for (int i = 0; i < 3; i++)
      begin
        // Lag of 8'hFF never grants, to force a timeout
        if (!rtsOut[i])
        begin
          waitCnt[i] <= 8'h00;
          ctsIn[i] <= 1'b0;
        end
        else if (waitCnt[i] == ctsLag && ctsLag != 8'hFF)
          ctsIn[i] <= 1'b1;
        else
          waitCnt[i] <= waitCnt[i] + 8'h01;
      end
    end
  end
endmodule

// file: spm_mode_select_test.sv
`timescale 1ns/1ps
module test_spm_mode_select;
  localparam int unsigned MS = 10;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [15:0] regWrData = 16'h0000;
  logic regWrEn = 1'b0, regRdEn = 1'b0, paramSwDefault = 1'b1, faultIn = 1'b0;
  logic takeoverReq = 1'b0, cycleStart = 1'b0, logicDone = 1'b0, rioPollNext = 1'b0;
  logic [3:0] modeSw = 4'h8;
  logic [2:0] rioBaudSw = 3'h0, monStart = 3'h0, monEnd = 3'h0;
  logic [15:0] regRdData;
  logic [2:0] frameRx, ctsIn, rtsOut, txGo, rspDrop, monGrant, rioPollAddr;
  logic [2:0] baudP2p, baudMdA, baudMdB;
  logic commWindow, unitActive, remoteMaster, holdBlink;
  logic [6:0] slaveAddr, a;
  logic [2:0] bp, bm;
  logic sendReq = 1'b0;
  logic [1:0] sendChan = 2'h0;
  logic [7:0] ctsLag = 8'h00;
  logic rdPend = 1'b0;
  logic [15:0] rdQ [$];
  logic [5:0] evQ [$];
  int miscompares = 0;
  int tests_run = 0;
  int n, n0;
  logic [7:0] rstOff [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
  logic [15:0] rstVal [6] = '{16'h0001, 16'h0000, 16'h0000, 16'h0064, 16'h0000, 16'h0000};

  spm_mode_select #(.MS_CYCLES(MS)) spm_mode_select_i (
    .sys_clk, .rst, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData, .paramSwDefault,
    .modeSw, .rioBaudSw, .frameRx, .ctsIn, .rtsOut, .txGo, .rspDrop, .monStart, .monEnd,
    .monGrant, .cycleStart, .logicDone, .commWindow, .faultIn, .takeoverReq, .unitActive,
    .remoteMaster, .rioPollNext, .rioPollAddr, .slaveAddr, .baudP2p, .baudMdA, .baudMdB,
    .holdBlink
  );
  spm_host_model spm_host_model_i (
    .sys_clk, .rst, .sendReq, .sendChan, .ctsLag, .rtsOut, .frameRx, .ctsIn
  );

  initial
  begin
    forever #2.5 sys_clk = ~sys_clk;
  end

  task summarize();
    if (miscompares == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] g);
    tests_run++;
    if ((g >= lo && g <= hi) !== 1'b1)
    begin
      $display("unexpected %s expected %0h..%0h seen %0h", nm, lo, hi, g);
      miscompares++;
    end
  endtask
  task bound(input int k);
    if (k >= 3000)
    begin
      miscompares++;
      summarize();
    end
  endtask
  task tick(input int k);
    repeat (k) @(posedge sys_clk);
  endtask
  task wr(input logic [7:0] ad, input logic [15:0] d);
    @(posedge sys_clk);
    regAddr <= ad;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge sys_clk);
    regWrEn <= 1'b0;
  endtask
  task rd(input logic [7:0] ad, input logic [15:0] e);
    @(posedge sys_clk);
    regAddr <= ad;
    regRdEn <= 1'b1;
    rdQ.push_back(e);
    @(posedge sys_clk);
    regRdEn <= 1'b0;
  endtask
  task frame(input int ch);
    @(posedge sys_clk);
    sendChan <= ch[1:0];
    sendReq <= 1'b1;
    @(posedge sys_clk);
    sendReq <= 1'b0;
  endtask
  // Delay counted from the frame request; tmo > 0 checks the request line drops after tmo ms
  task resp(input int ch, input int lag, input logic [5:0] pat, input int dly, input int tmo);
    ctsLag <= lag[7:0];
    evQ.push_back(pat);
    frame(ch);
    for (n = 0; !rtsOut[ch] && n < 3000; n++) @(negedge sys_clk);
    bound(n);
    chk("reply delay", dly * MS, dly * MS + 4, n);
    for (n = 0; rtsOut[ch] && n < 3000; n++) @(negedge sys_clk);
    bound(n);
    if (tmo > 0)
      chk("handshake wait", tmo * MS - 1, tmo * MS + 2, n);
    tick(3);
  endtask
  task scan(output int w);
    cycleStart <= 1'b1;
    tick(1);
    cycleStart <= 1'b0;
    tick(59);
    logicDone <= 1'b1;
    tick(1);
    logicDone <= 1'b0;
    w = 0;
    repeat (100)
    begin
      tick(1);
      w += int'(commWindow);
    end
  endtask

  always @(posedge sys_clk)
    rdPend <= regRdEn;
  always @(negedge sys_clk)
  begin
    if (rdPend)
      chk("read data", rdQ[0], rdQ[0], regRdData);
    if (rdPend)
      void'(rdQ.pop_front());
    if ((txGo | rspDrop) != 3'h0)
      chk("reply event", evQ[0], evQ[0], {rspDrop, txGo});
    if ((txGo | rspDrop) != 3'h0)
      void'(evQ.pop_front());
  end

  initial
  begin
    void'($urandom(32'h900FEA6C));
    tick(2);
    rst <= 1'b0;
    tick(2);
    for (int i = 0; i < 6; i++) rd(rstOff[i], rstVal[i]);
    // Unmapped offsets read back as zero
    rd(8'h22, 16'h0000);
    wr(8'h18, 16'hFFFF);
    rd(8'h18, 16'h0204);
    a = 7'($urandom_range(127, 2));
    bp = 3'($urandom);
    bm = 3'($urandom);
    wr(8'h00, {9'h000, a});
    wr(8'h04, {13'h0000, bp});
    wr(8'h08, {13'h0000, bm});
    rd(8'h1C, 16'h0001);
    paramSwDefault <= 1'b0;
    tick(2);
    rd(8'h1C, {bm, bm, bp, a});
    a = 7'($urandom_range(127, 2));
    wr(8'h00, {9'h000, a});
    rd(8'h1C, {bm, bm, bp, a});
    chk("address port", a, a, slaveAddr);
    chk("p2p baud port", bp, bp, baudP2p);
    chk("multidrop baud port", bm, bm, baudMdA);
    frame(0);
    tick(90);
    chk("passive request", 0, 0, rtsOut);
    takeoverReq <= 1'b1;
    tick(3);
    takeoverReq <= 1'b0;
    tick(3);
    chk("unit active", 1, 1, unitActive);
    resp(0, 3, 6'h01, 7, 0);
    wr(8'h10, 16'h0005);
    resp(1, 0, 6'h02, 5, 0);
    wr(8'h0C, 16'h0002);
    resp(2, 255, 6'h20, 5, 2);
    wr(8'h14, 16'h0000);
    scan(n);
    scan(n0);
    chk("window default", 31, 33, n0);
    wr(8'h14, 16'h0028);
    scan(n);
    chk("window scaled", 2 * n0 - 3, 2 * n0 + 3, n);
    monStart <= 3'b110;
    tick(1);
    monStart <= 3'b001;
    tick(1);
    monStart <= 3'b000;
    tick(2);
    chk("monitor grant", 2, 2, monGrant);
    monEnd <= 3'b010;
    tick(1);
    monEnd <= 3'b000;
    tick(2);
    chk("monitor free", 0, 0, monGrant);
    faultIn <= 1'b1;
    tick(3);
    chk("fault handover", 0, 0, unitActive);
    faultIn <= 1'b0;
    rioBaudSw <= 3'($urandom);
    modeSw <= 4'h0;
    takeoverReq <= 1'b1;
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    tick(4);
    chk("remote mode", 1, 1, remoteMaster);
    rd(8'h1C, {rioBaudSw, 3'h0, 3'h0, 7'h01});
    chk("remote baud port", rioBaudSw, rioBaudSw, baudMdB);
    frame(2);
    tick(90);
    chk("third port idle", 0, 0, rtsOut);
    for (int i = 0; i < 7; i++)
    begin
      chk("poll address", i % 6 + 1, i % 6 + 1, rioPollAddr);
      rioPollNext <= 1'b1;
      tick(1);
      rioPollNext <= 1'b0;
      tick(2);
    end
    modeSw <= 4'h7;
    paramSwDefault <= 1'b1;
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    tick(4);
    rd(8'h18, 16'h01CD);
    for (n = 0; !holdBlink && n < 3000; n++) @(negedge sys_clk);
    bound(n);
    chk("hold blink", 2490, 2510, n);
    chk("queues drained", 0, 0, rdQ.size() + evQ.size());
    summarize();
  end
endmodule
